// File: sdet_regs.svh
// constants of the stall motion detector: field widths, reset values,
// back emf sample delays and their cycle counts at the system clock.
// assumes one 125 mhz clock; included by the package and the assertion module.
`ifndef SDET_REGS_SVH
`define SDET_REGS_SVH

// ****************************************************************
// clock and widths
// ****************************************************************
`define SDET_CLK_MHZ      125
`define SDET_THR_W        4
`define SDET_DSEL_W       3
`define SDET_ARM_W        3
`define SDET_POS_W        16
`define SDET_CNT_W        24

// ****************************************************************
// threshold off code and reset codes
// ****************************************************************
`define SDET_THR_OFF      4'h0
`define SDET_DSEL_RST     3'h0
`define SDET_ARM_RST      3'h0

// ****************************************************************
// sample delay after a zero crossing, microseconds then cycles
// ****************************************************************
`define SDET_TDELAY0_US   87
`define SDET_TDELAY1_US   130
`define SDET_TDELAY2_US   174
`define SDET_TDELAY3_US   217
`define SDET_TDELAY4_US   304
`define SDET_TDELAY5_US   391
`define SDET_TDELAY6_US   521
`define SDET_TDELAY7_US   694
`define SDET_US2CYC(us)   ((us) * `SDET_CLK_MHZ)

// ****************************************************************
// stabilisation wait between the two phases of a move
// ****************************************************************
`define SDET_TSTAB_US     1000
`define SDET_TSTAB_CYC    `SDET_US2CYC(`SDET_TSTAB_US)

`endif

// File: sdet_pkg.sv
// types of the stall motion detector: controller states and the
// registered state of the top module.
// assumes sdet_regs.svh is on the include path.
`include "sdet_regs.svh"

package sdet_pkg;

  // ****************************************************************
  // detection controller states
  // ****************************************************************
  typedef enum logic [1:0] {
    SDET_IDLE,     // no ramp finished, detection not armed
    SDET_ARMING,   // at top speed, counting extra full steps
    SDET_ARMED,    // samples are compared with the threshold
    SDET_STAB      // waiting before the second phase starts
  } sdet_state_e;

  typedef logic [`SDET_CNT_W-1:0] sdet_cnt_t;  // cycle counter word
  typedef logic [`SDET_POS_W-1:0] sdet_pos_t;  // position word

  // ****************************************************************
  // whole state of the top module
  // ****************************************************************
  typedef struct packed {
    sdet_state_e             st;        // controller state
    logic [2:0]              zc_sync;   // zero crossing synchroniser
    logic [`SDET_ARM_W-1:0]  arm_cnt;   // full steps since top speed
    sdet_cnt_t               stab_cnt;  // stabilisation countdown
    logic [`SDET_THR_W-1:0]  thr;       // working threshold
    logic [`SDET_DSEL_W-1:0] dsel;      // working sample delay code
    logic [`SDET_ARM_W-1:0]  arm_dly;   // working activation delay
    logic                    fd_en;     // detect at full duty
    logic                    stall;     // sticky stall flag
    logic                    abs_blk;   // sticky absolute stall flag
    logic                    step_loss; // sticky step loss flag
    logic                    hstop;     // internal hard stop pulse
    logic                    ph2_go;    // second phase start pulse
    logic                    otp_stb;   // nonvolatile write pulse
    logic [`SDET_THR_W-1:0]  otp_thr;   // nonvolatile write data
    sdet_pos_t               act_pos;   // actual position register
  } sdet_state_s;

  // ****************************************************************
  // delay timer state
  // ****************************************************************
  typedef struct packed {
    logic      busy;  // a delay is running
    logic      done;  // one cycle pulse at expiry
    sdet_cnt_t cnt;   // cycles still to wait
  } sdet_tmr_s;

endpackage

// File: sdet_delay_timer.sv
// sample delay timer: started by a zero crossing, pulses done when
// the loaded number of cycles has passed.
// assumes start is a one cycle pulse on the same clock.
`timescale 1ns/1ps

module sdet_delay_timer
  import sdet_pkg::*;
(
  input  wire logic      clock,   // system clock
  input  wire logic      reset,   // synchronous, active high
  input  wire logic      start,   // restart the delay
  input  wire sdet_cnt_t cycles,  // delay length in cycles
  output logic           done     // one cycle pulse at expiry
);

  sdet_tmr_s s_q;  // registered state
  sdet_tmr_s s_d;  // next state

  // ****************************************************************
  // countdown
  // ****************************************************************
  // a new crossing restarts the delay; an old sample is then lost,
  // which is wanted since it belongs to the previous half step
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.busy = 1'b1;
      s_d.cnt  = (cycles > 1) ? cycles - sdet_cnt_t'(1) : '0;
    end else if (s_q.busy) begin
      if (s_q.cnt == '0) begin                // delay expired
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - sdet_cnt_t'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;

endmodule

// File: sdet_stall_detect.sv
// stall motion detector: back emf sample versus absolute threshold,
// armed at top speed after extra full steps, sticky flags, hard stop.
// assumes motion controller signals and back emf code share the clock;
// the zero crossing comparator output is asynchronous.
`timescale 1ns/1ps

module sdet_stall_detect
  import sdet_pkg::*;
#(
  parameter int unsigned DELAY_CYC [8] = '{
    `SDET_US2CYC(`SDET_TDELAY0_US), `SDET_US2CYC(`SDET_TDELAY1_US),
    `SDET_US2CYC(`SDET_TDELAY2_US), `SDET_US2CYC(`SDET_TDELAY3_US),
    `SDET_US2CYC(`SDET_TDELAY4_US), `SDET_US2CYC(`SDET_TDELAY5_US),
    `SDET_US2CYC(`SDET_TDELAY6_US), `SDET_US2CYC(`SDET_TDELAY7_US)},
  parameter int unsigned TSTAB_CYC = `SDET_TSTAB_CYC
)(
  input  wire logic                    clock,         // 125 mhz clock
  input  wire logic                    reset,         // sync, high
  input  wire logic                    zero_cross,    // async crossing
  input  wire logic [`SDET_THR_W-1:0]  bemf_level,    // sampled emf code
  input  wire logic                    at_max_vel,    // ramp done
  input  wire logic                    full_step,     // full step pulse
  input  wire logic                    move_active,   // positioning
  input  wire logic                    two_phase_move,// dual move
  input  wire logic                    phase_one,     // in first phase
  input  wire logic                    full_duty,     // pwm at 100 %
  input  wire sdet_pos_t               position_cnt,  // internal counter
  input  wire logic                    read_all_status_cmd,   // pulse
  input  wire logic                    read_short_status_cmd, // pulse
  input  wire logic                    write_detect_param_cmd,// pulse
  input  wire logic [`SDET_THR_W-1:0]  wr_threshold,  // new threshold
  input  wire logic [`SDET_DSEL_W-1:0] wr_delay_sel,  // new delay code
  input  wire logic [`SDET_ARM_W-1:0]  wr_arm_steps,  // new arm delay
  input  wire logic                    wr_fd_en,      // new duty enable
  input  wire logic                    write_nv_param_cmd,    // pulse
  input  wire logic [`SDET_THR_W-1:0]  nv_threshold,  // stored nv value
  input  wire logic [`SDET_DSEL_W-1:0] nv_delay_sel,  // stored nv code
  input  wire logic [`SDET_ARM_W-1:0]  nv_arm_steps,  // stored nv steps
  input  wire logic                    nv_fd_en,      // stored nv enable
  output logic                         otp_prog_stb,  // nv write pulse
  output logic [`SDET_THR_W-1:0]       otp_prog_thr,  // nv write data
  output logic                         stall_flag,    // sticky stall
  output logic                         abs_block_flag,// sticky abs stall
  output logic                         step_loss_flag,// sticky step loss
  output logic                         move_blocked,  // new moves held
  output logic                         hard_stop,     // stop pulse
  output logic                         phase_two_go,  // slow phase pulse
  output logic                         detect_armed,  // comparing now
  output sdet_pos_t                    actual_position// position reg
);

  sdet_state_s s_q;          // registered state
  sdet_state_s s_d;          // next state
  logic        zc_rise;      // synchronised crossing event
  logic        sample_stb;   // sample instant
  logic        det_enabled;  // threshold nonzero
  logic        suppressed;   // full duty with detection off
  logic        stall_hit;    // valid low sample
  sdet_cnt_t   delay_cyc;    // selected sample delay

  // ****************************************************************
  // crossing event and sample delay
  // ****************************************************************
  // change counts while the second stage is high and the third is still low
  assign zc_rise = s_q.zc_sync[1] & ~s_q.zc_sync[2];

  // delay table lookup, one entry per code
  assign delay_cyc = sdet_cnt_t'(DELAY_CYC[s_q.dsel]);

  sdet_delay_timer u_timer (
    .clock  (clock),
    .reset  (reset),
    .start  (zc_rise),
    .cycles (delay_cyc),
    .done   (sample_stb)
  );

  // ****************************************************************
  // detection qualifiers
  // ****************************************************************
  // code zero means off; any other code is a rising level, so a
  // plain magnitude compare of the codes follows the level table
  assign det_enabled = (s_q.thr != `SDET_THR_OFF);
  assign suppressed  = full_duty & ~s_q.fd_en;
  // a sample only counts while armed at top speed; early, disabled
  // or suppressed samples are dropped without touching the flags
  assign stall_hit = sample_stb && (s_q.st == SDET_ARMED)
                     && at_max_vel && det_enabled
                     && !suppressed
                     && (bemf_level < s_q.thr);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d         = s_q;
    s_d.zc_sync = {s_q.zc_sync[1:0], zero_cross};
    s_d.hstop   = 1'b0;
    s_d.ph2_go  = 1'b0;
    s_d.otp_stb = 1'b0;

    // parameter writes; the working copy is what detection uses
    if (write_detect_param_cmd) begin
      s_d.thr     = wr_threshold;
      s_d.dsel    = wr_delay_sel;
      s_d.arm_dly = wr_arm_steps;
      s_d.fd_en   = wr_fd_en;
    end
    // nonvolatile write is passed out; working copy is untouched
    if (write_nv_param_cmd) begin
      s_d.otp_stb = 1'b1;
      s_d.otp_thr = wr_threshold;
    end

    // normal tracking of the position while a move runs
    if (move_active) begin
      s_d.act_pos = position_cnt;
    end

    // status reads clear first so that a stall in the same cycle wins
    if (read_all_status_cmd) begin
      s_d.stall     = 1'b0;
      s_d.abs_blk   = 1'b0;
      s_d.step_loss = 1'b0;
    end else if (read_short_status_cmd) begin
      s_d.step_loss = 1'b0;
    end

    unique case (s_q.st)
      // wait for the end of the acceleration ramp
      SDET_IDLE: begin
        s_d.arm_cnt = '0;
        if (at_max_vel && move_active && det_enabled) begin
          s_d.st = (s_q.arm_dly == '0) ? SDET_ARMED : SDET_ARMING;
        end
      end
      // extra full steps before comparing
      SDET_ARMING: begin
        if (!at_max_vel || !move_active || !det_enabled) begin
          s_d.st = SDET_IDLE;
        end else if (full_step) begin
          s_d.arm_cnt = s_q.arm_cnt + 3'h1;
          if (s_q.arm_cnt + 3'h1 == s_q.arm_dly) begin
            s_d.st = SDET_ARMED;
          end
        end
      end
      // compare each delayed sample with the threshold
      SDET_ARMED: begin
        if (stall_hit) begin
          s_d.stall   = 1'b1;
          s_d.abs_blk = 1'b1;
          s_d.st      = SDET_IDLE;
          if (move_active) begin
            s_d.hstop     = 1'b1;
            s_d.step_loss = 1'b1;
            s_d.act_pos   = position_cnt;
            if (two_phase_move && phase_one) begin
              s_d.st       = SDET_STAB;
              s_d.stab_cnt = sdet_cnt_t'(TSTAB_CYC);
            end
          end
        end else if (!at_max_vel || !move_active || !det_enabled) begin
          s_d.st = SDET_IDLE;
        end
      end
      // hold still, then start the slow second phase
      SDET_STAB: begin
        if (s_q.stab_cnt <= sdet_cnt_t'(1)) begin
          s_d.ph2_go = 1'b1;
          s_d.st     = SDET_IDLE;
        end else begin
          s_d.stab_cnt = s_q.stab_cnt - sdet_cnt_t'(1);
        end
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset copies the nonvolatile fields into the working copy;
  // reset is synchronous so sampling the ports here is safe
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q         <= '0;
      s_q.st      <= SDET_IDLE;
      s_q.thr     <= nv_threshold;
      s_q.dsel    <= nv_delay_sel;
      s_q.arm_dly <= nv_arm_steps;
      s_q.fd_en   <= nv_fd_en;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign otp_prog_stb    = s_q.otp_stb;
  assign otp_prog_thr    = s_q.otp_thr;
  assign stall_flag      = s_q.stall;
  assign abs_block_flag  = s_q.abs_blk;
  assign step_loss_flag  = s_q.step_loss;
  // only step loss holds off new moves; a short read releases them
  assign move_blocked    = s_q.step_loss;
  assign hard_stop       = s_q.hstop;
  assign phase_two_go    = s_q.ph2_go;
  assign detect_armed    = (s_q.st == SDET_ARMED);
  assign actual_position = s_q.act_pos;

endmodule

// File: sdet_motor_model.sv
// motor stand-in: emf crossings, full steps, ramp and emf level.
// assumes the bench raises run for a move; 40 cycles per full step.
`timescale 1ns/1ps
module sdet_motor_model (
  input  wire logic  clock,      // system clock
  input  wire logic  reset,      // sync, high
  input  wire logic  run,        // move running
  input  wire logic  blocked,    // rotor held at the end stop
  output logic       zero_cross, // crossing, high half a step
  output logic       full_step,  // one pulse a step
  output logic       at_max_vel, // three step ramp done
  output logic [3:0] bemf_level  // emf code, low when held
);
  // ****************
  // step phase and ramp, both restart whenever run drops
  // ****************
  logic [5:0] ph_q; // phase within a step
  logic [1:0] rp_q; // ramp steps done
  always_ff @(posedge clock) begin
    ph_q <= (reset || !run || ph_q == 6'h27) ? 6'h00 : ph_q + 6'h01;
    rp_q <= (reset || !run) ? 2'h0 : rp_q + 2'(full_step && rp_q != 2'h3);
  end
  // a stopped motor leaves the crossing line low, no free running
  assign zero_cross = run && ph_q >= 6'h14;
  assign full_step  = run && ph_q == 6'h27;
  assign at_max_vel = rp_q == 2'h3;
  assign bemf_level = blocked ? 4'h1 : 4'h9;
endmodule

// File: sdet_stall_sva.sv
// assertions on the stall detector ports, bound to its top module.
// assumes one clock and the synchronous active high reset.
`timescale 1ns/1ps
`include "sdet_regs.svh"
module sdet_stall_sva
  import sdet_pkg::*;
#(
  parameter int unsigned TSTAB_CYC = `SDET_TSTAB_CYC // slow start wait
)(
  input wire logic      clock,                 // clock
  input wire logic      reset,                 // sync high
  input wire logic      at_max_vel,            // ramp done
  input wire logic      two_phase_move,        // dual move
  input wire logic      phase_one,             // first phase
  input wire sdet_pos_t position_cnt,          // counter
  input wire logic      read_all_status_cmd,   // full read
  input wire logic      read_short_status_cmd, // short read
  input wire logic      stall_flag,            // stall
  input wire logic      abs_block_flag,        // abs stall
  input wire logic      step_loss_flag,        // step loss
  input wire logic      hard_stop,             // stop pulse
  input wire logic      phase_two_go,          // slow phase
  input wire logic      detect_armed,          // armed
  input wire sdet_pos_t actual_position        // position
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic        pend_q; // second phase still owed
  int unsigned wait_q; // edges since the first phase stall
  // count edges from a first phase stall up to the slow start
  always_ff @(posedge clock) begin
    pend_q <= !reset && !phase_two_go
      && (pend_q || (hard_stop && two_phase_move && phase_one));
    wait_q <= pend_q ? wait_q + 1 : 1;
  end
  // ****************
  // properties
  // ****************
  property p_full; read_all_status_cmd && !detect_armed |=> !stall_flag
    && !abs_block_flag && !step_loss_flag; endproperty
  a_full: assert property (p_full)
    else $error("flags survive a full status read");
  property p_short; read_short_status_cmd && !read_all_status_cmd
    && !detect_armed |=> !step_loss_flag
    && stall_flag == $past(stall_flag); endproperty
  a_short: assert property (p_short)
    else $error("short read cleared the wrong flags");
  property p_hold; stall_flag && !read_all_status_cmd |=> stall_flag;
  endproperty
  a_hold: assert property (p_hold)
    else $error("stall flag dropped without a full read");
  property p_step; $rose(step_loss_flag) |-> hard_stop && stall_flag
    && abs_block_flag; endproperty
  a_step: assert property (p_step)
    else $error("step loss without stop and stall flags");
  property p_rose; $rose(stall_flag) |-> $past(detect_armed)
    && $past(at_max_vel); endproperty
  a_rose: assert property (p_rose)
    else $error("stall raised while not armed at top speed");
  property p_copy; hard_stop |-> actual_position == $past(position_cnt);
  endproperty
  a_copy: assert property (p_copy)
    else $error("position not copied on the hard stop");
  property p_stab_max; pend_q |-> wait_q <= TSTAB_CYC; endproperty
  a_stab_max: assert property (p_stab_max)
    else $error("second phase start overdue");
  // the slow start is seen exactly one wait after the stop is seen
  property p_stab_min; phase_two_go |-> pend_q && wait_q == TSTAB_CYC;
  endproperty
  a_stab_min: assert property (p_stab_min)
    else $error("second phase start early or uncalled");
  c_stop: cover property (hard_stop && phase_one);
  c_slow: cover property (phase_two_go);
  c_short: cover property (read_short_status_cmd && stall_flag);
endmodule
bind sdet_stall_detect sdet_stall_sva #(.TSTAB_CYC(TSTAB_CYC)) chk_u (
  .clock(clock), .reset(reset), .at_max_vel(at_max_vel),
  .two_phase_move(two_phase_move), .phase_one(phase_one),
  .position_cnt(position_cnt), .read_all_status_cmd(read_all_status_cmd),
  .read_short_status_cmd(read_short_status_cmd), .stall_flag(stall_flag),
  .abs_block_flag(abs_block_flag), .step_loss_flag(step_loss_flag),
  .hard_stop(hard_stop), .phase_two_go(phase_two_go),
  .detect_armed(detect_armed), .actual_position(actual_position));

// File: tb.sv
// bench of the stall detector against the motor stand-in.
// assumes short delay and wait parameters; results judged at ports.
`timescale 1ns/1ps
module tb;
  import sdet_pkg::*;
  logic       clock, reset, run, blk, tph, fduty; // bench levels
  logic       rd_all, rd_sh, wr_cmd, nv_cmd, wfd; // command pulses
  logic [3:0] wthr, bemf, othr, nthr;             // thresholds, emf
  logic [2:0] wsel, warm;                         // delay, arm data
  logic       zc, fs, amv, stb, stall, absf;      // motor, flags
  logic       sloss, mblk, hstop, p2, armed;      // status, events
  sdet_pos_t  pos, act;                           // positions
  int         n_fail = 0, checks_done = 0, cyc = 0; // bookkeeping
  sdet_stall_detect #(.DELAY_CYC('{4, 5, 6, 7, 8, 9, 10, 11}),
    .TSTAB_CYC(20)) dut_u (
    .clock(clock), .reset(reset), .zero_cross(zc), .bemf_level(bemf),
    .at_max_vel(amv), .full_step(fs), .move_active(run),
    .two_phase_move(tph), .phase_one(tph), .full_duty(fduty),
    .position_cnt(pos), .read_all_status_cmd(rd_all),
    .read_short_status_cmd(rd_sh), .write_detect_param_cmd(wr_cmd),
    .wr_threshold(wthr), .wr_delay_sel(wsel), .wr_arm_steps(warm),
    .wr_fd_en(wfd), .write_nv_param_cmd(nv_cmd), .nv_threshold(nthr),
    .nv_delay_sel(3'h7), .nv_arm_steps(3'h0), .nv_fd_en(1'b0),
    .otp_prog_stb(stb), .otp_prog_thr(othr), .stall_flag(stall),
    .abs_block_flag(absf), .step_loss_flag(sloss), .move_blocked(mblk),
    .hard_stop(hstop), .phase_two_go(p2), .detect_armed(armed),
    .actual_position(act));
  sdet_motor_model motor_u (.clock(clock), .reset(reset), .run(run),
    .blocked(blk), .zero_cross(zc), .full_step(fs), .at_max_vel(amv),
    .bemf_level(bemf));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // position moves every cycle so a stale copy shows up
  always @(posedge clock) pos <= reset ? 16'h0000 : pos + 16'h0001;
  // hang guard, far above the few thousand cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic setp(logic [3:0] t, logic [2:0] s, logic [2:0] a, logic f);
    {wthr, wsel, warm, wfd, wr_cmd} = {t, s, a, f, 1'b1};
    tick(1);
    wr_cmd = 1'b0;
  endtask
  // zero threshold copied from nv at reset keeps detection off
  task automatic t_off();
    int i;
    {run, blk} = 2'b11;
    tick(400);
    chk(16'({armed, stall}), 16'h0);
    {run, wthr, nv_cmd} = {1'b0, 4'ha, 1'b1};
    tick(1);
    nv_cmd = 1'b0;
    chk(16'({stb, othr}), 16'h1a);
    // a nonzero stored threshold must arm on its own after a new reset
    {nthr, reset} = {4'h6, 1'b1};
    tick(2);
    {reset, run, blk} = 3'b010;
    for (i = 0; i < 400 && armed !== 1'b1; i++) tick(1);
    chk(16'(armed), 16'h1);
    run = 1'b0;
    tick(2);
    $display("test off done");
  endtask
  // count full steps between end of ramp and arming
  task automatic t_arm(logic [2:0] a);
    int n;
    int i;
    n = 0;
    setp(4'h6, 3'h7, a, 1'b0);
    {blk, run} = 2'b01;
    for (i = 0; i < 300 && amv !== 1'b1; i++) tick(1);
    for (i = 0; i < 400 && armed !== 1'b1; i++) begin
      n += int'(fs);
      tick(1);
    end
    chk(16'(n), 16'(a));
    tick(200);
    chk(16'(stall), 16'h0);
    run = 1'b0;
    tick(2);
    chk(16'(armed), 16'h0);
    $display("test arm %0d done", a);
  endtask
  // blocked rotor: ignored in the ramp, then stop, copy, reads
  task automatic t_stall(logic tp);
    sdet_pos_t p;
    int i;
    int z = 0;
    logic zp;
    setp(4'h6, {2'h0, tp}, 3'h1, 1'b0);
    {tph, blk, run} = {tp, 2'b11};
    for (i = 0; i < 300 && amv !== 1'b1; i++) tick(1);
    chk(16'(stall), 16'h0);
    // z counts edges since the crossing rose
    for (i = 0; i < 300 && hstop !== 1'b1; i++) begin
      p = pos;
      zp = zc;
      tick(1);
      z = (zc && !zp) ? 0 : z + 1;
    end
    chk(16'({hstop, stall, absf, sloss}), 16'hf);
    // three sync stages, the selected delay of 4 or 5, one flag edge
    chk(16'(z), 16'h8 + 16'(tp));
    run = 1'b0;
    for (i = 0; tp && i < 60 && p2 !== 1'b1; i++) tick(1);
    chk(16'(!tp || i == 20), 16'h1);
    {tph, rd_sh} = 2'b01;
    tick(1);
    rd_sh = 1'b0;
    chk(16'({stall, absf, sloss, mblk}), 16'hc);
    rd_all = 1'b1;
    tick(1);
    rd_all = 1'b0;
    chk(16'({stall, absf, sloss}), 16'h0);
    chk(act, p);
    $display("test stall %0d done", tp);
  endtask
  // full duty hides a stall until its enable bit is set
  task automatic t_duty();
    int i;
    setp(4'h6, 3'h2, 3'h0, 1'b0);
    {fduty, blk, run} = 3'b111;
    for (i = 0; i < 400 && armed !== 1'b1; i++) tick(1);
    tick(200);
    chk(16'(stall), 16'h0);
    setp(4'h6, 3'h2, 3'h0, 1'b1);
    for (i = 0; i < 200 && hstop !== 1'b1; i++) tick(1);
    chk(16'({hstop, stall}), 16'h3);
    {run, fduty, rd_all} = 3'b001;
    tick(1);
    rd_all = 1'b0;
    $display("test duty done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {reset, run, blk, tph, fduty, rd_all, rd_sh} = 7'h40;
    {wr_cmd, nv_cmd, wfd, wthr, wsel, warm} = 13'h0000;
    nthr = 4'h0;
    tick(10);
    reset = 1'b0;
    t_off();
    t_arm(3'h0);
    t_arm(3'h3);
    t_arm(3'h7);
    t_stall(1'b0);
    t_stall(1'b1);
    t_duty();
    end_of_test();
  end
endmodule
